/* File: hcs_defines.svh */
// How it works
// - with address match on, keep only packets for our address or all-call
// - receiver on starts flag hunting at once
// - receiver off finishes the arriving packet, then stops its clock
// - transmitter on starts at once with one byte of ones, then an opening flag and data if queued, else selected fill
// - transmitter off finishes the packet in flight, then stops its clock
// - packet-end tag rides on next fifo byte, FCS follows, tag self-clears
// - abort tag rides on next fifo byte, packet aborted, tag self-clears
// - empty transmit fifo: idle ones if fill bit zero, else flags
// - interrupt-pending sets on unmasked interrupt, clears on interrupt read
// - line-idle sets after 15 or more ones received
// - bits 5:4 give the type of the last byte read from rx fifo
// - bits 3:2 give the transmit fifo level code
// - transmit fifo entries hold byte plus both tags, ten bits
// - bits 1:0 give the receive fifo level code
`ifndef HCS_DEFINES_SVH
`define HCS_DEFINES_SVH
`define HCS_IDX_FIFO 6'h12
`define HCS_IDX_CTRL1 6'h13
`define HCS_IDX_STAT 6'h14
`define HCS_IDX_IRQST 6'h20
`define HCS_IDX_IRQMSK 6'h21
`define HCS_CTRL1_RST 8'h00
`define HCS_C1_ADREC 7
`define HCS_C1_RXON 6
`define HCS_C1_TXON 5
`define HCS_C1_EOP 4
`define HCS_C1_ABORT 3
`define HCS_C1_FILL 2
`define HCS_EV_RXOVF 0
`define HCS_EV_RXEOP 1
`define HCS_EV_TXEOP 2
`define HCS_EV_TXABT 3
`define HCS_FLAG 8'h7e
`define HCS_ONES 8'hff
`define HCS_ALLCALL 7'h7f
`define HCS_CRC_INIT 16'hffff
`define HCS_CRC_POLY 16'h8408
`define HCS_CRC_GOOD 16'hf0b8
`define HCS_IDLE_ONES 4'd15
`define HCS_RQ_PKT 2'b00
`define HCS_RQ_FIRST 2'b01
`define HCS_RQ_GOOD 2'b10
`define HCS_RQ_BAD 2'b11
`define HCS_CLK_NS 50
`define HCS_BIT_NS 15625
`define HCS_BIT_CYC (`HCS_BIT_NS / `HCS_CLK_NS)
`endif

/* File: hcs_pkg.sv */
`default_nettype none
package hcs_pkg;
  typedef struct packed {
    logic eop;
    logic abort;
    logic [7:0] data;
  } hcs_tx_entry_t;
  typedef struct packed {
    logic [1:0] kind;
    logic [7:0] data;
  } hcs_rx_entry_t;
  typedef enum logic [7:0] {
    TS_OFF = 8'h01, TS_IDLE = 8'h02, TS_OPEN = 8'h04, TS_DATA = 8'h08,
    TS_FCS1 = 8'h10, TS_FCS2 = 8'h20, TS_CLOSE = 8'h40, TS_ABORT = 8'h80
  } hcs_tx_state_t;
endpackage : hcs_pkg
`default_nettype wire

/* File: hcs_hdlc_ctl.sv */
// Design decision made here: the Wishbone interface to the registers.
`include "hcs_defines.svh"
`default_nettype none
module hcs_hdlc_ctl #(
  parameter int unsigned DEPTH = 16,
  parameter int unsigned STAT_LVL = 12,
  parameter int unsigned INT_LVL = 8,
  parameter int unsigned BIT_CYC = `HCS_BIT_CYC,
  parameter logic [6:0] RECOG_ADDR = 7'h01
) (
  // system
  input wire logic clk,
  input wire logic reset_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial link
  input wire logic rxBit,
  output logic txBit,
  output logic bitStrobe,
  // interrupt
  output logic irq
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] STATL = (AW+1)'(STAT_LVL);
  localparam logic [AW:0] INTL = (AW+1)'(INT_LVL);
  function automatic logic [15:0] crcByte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ d[i]) ? ((r >> 1) ^ `HCS_CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crcByte
  // bus decode
  logic wbReq, wbWr, wbRd, wrCtrl, wrFifo, wrIrq, wrMask, rdFifo, rdIrq;
  logic [5:0] idx;
  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign idx = wb_adr_i[7:2];
  assign wbWr = wbReq && wb_we_i && wb_sel_i[0];
  assign wbRd = wbReq && !wb_we_i;
  assign wrCtrl = wbWr && idx == `HCS_IDX_CTRL1;
  assign wrFifo = wbWr && idx == `HCS_IDX_FIFO;
  assign wrIrq = wbWr && idx == `HCS_IDX_IRQST;
  assign wrMask = wbWr && idx == `HCS_IDX_IRQMSK;
  assign rdFifo = wbRd && idx == `HCS_IDX_FIFO;
  assign rdIrq = wbRd && idx == `HCS_IDX_IRQST;
  logic [7:0] ctrl1;
  logic txOn, rxOn;
  assign txOn = ctrl1[`HCS_C1_TXON];
  assign rxOn = ctrl1[`HCS_C1_RXON];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl1 <= `HCS_CTRL1_RST;
    end else if (wrCtrl) begin
      ctrl1 <= wb_dat_i[7:0];
    end else if (wrFifo) begin
      ctrl1[`HCS_C1_EOP] <= 1'b0;
      ctrl1[`HCS_C1_ABORT] <= 1'b0;
    end
  end
  // transmit fifo
  hcs_pkg::hcs_tx_entry_t txMem [DEPTH];
  logic [AW-1:0] txWp, txRp;
  logic [AW:0] txCnt;
  logic txPush, txPop;
  hcs_pkg::hcs_tx_entry_t txHead;
  assign txPush = wrFifo && txCnt != FULL;
  assign txHead = txMem[txRp];
  always_ff @(posedge clk) begin
    if (txPush) begin
      txMem[txWp] <= '{eop: ctrl1[`HCS_C1_EOP], abort: ctrl1[`HCS_C1_ABORT], data: wb_dat_i[7:0]};
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txWp <= '0;
      txRp <= '0;
      txCnt <= '0;
    end else begin
      if (txPush) txWp <= txWp + 1'b1;
      if (txPop) txRp <= txRp + 1'b1;
      txCnt <= txCnt + (AW+1)'(txPush) - (AW+1)'(txPop);
    end
  end
  // receive fifo, fed one cycle after the engine decides
  hcs_pkg::hcs_rx_entry_t rxMem [DEPTH];
  hcs_pkg::hcs_rx_entry_t rxPushEnt;
  logic [AW-1:0] rxWp, rxRp;
  logic [AW:0] rxCnt;
  logic rxPushV, rxPush, rxPop, rxOvf;
  logic [1:0] byteType;
  assign rxPush = rxPushV && rxCnt != FULL;
  assign rxOvf = rxPushV && rxCnt == FULL;
  assign rxPop = rdFifo && rxCnt != '0;
  always_ff @(posedge clk) begin
    if (rxPush) rxMem[rxWp] <= rxPushEnt;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxWp <= '0;
      rxRp <= '0;
      rxCnt <= '0;
      byteType <= `HCS_RQ_PKT;
    end else begin
      if (rxPush) rxWp <= rxWp + 1'b1;
      if (rxPop) begin
        rxRp <= rxRp + 1'b1;
        byteType <= rxMem[rxRp].kind;
      end
      rxCnt <= rxCnt + (AW+1)'(rxPush) - (AW+1)'(rxPop);
    end
  end
  // fifo level codes
  logic [1:0] txLevel, rxLevel;
  assign txLevel = (txCnt == '0) ? 2'b10 : (txCnt >= STATL) ? 2'b00 : (txCnt >= INTL) ? 2'b01 : 2'b11;
  assign rxLevel = (rxCnt == '0) ? 2'b00 : (rxCnt >= INTL) ? 2'b11 : (rxCnt >= STATL) ? 2'b10 : 2'b01;
  // bit-rate enable
  logic [15:0] divCnt;
  logic bitEn;
  assign bitEn = bitStrobe;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt <= '0;
      bitStrobe <= 1'b0;
    end else begin
      bitStrobe <= divCnt == 16'(BIT_CYC - 1);
      divCnt <= (divCnt == 16'(BIT_CYC - 1)) ? '0 : divCnt + 16'h0001;
    end
  end
  // transmitter
  hcs_pkg::hcs_tx_state_t txState;
  logic [7:0] txSh;
  logic [2:0] txBc, txOnes;
  logic txStuff, txStuffLast, txEopPend, txIns, txEnd;
  logic [15:0] txCrc;
  logic [1:0] txEv;
  // stuffing follows the last sent bit so a run ending a byte still gets its zero
  assign txIns = txStuffLast && txOnes == 3'd5;
  assign txEnd = bitEn && !txIns && txBc == 3'd7 && txState != hcs_pkg::TS_OFF;
  assign txPop = txEnd && (txState == hcs_pkg::TS_OPEN || txState == hcs_pkg::TS_DATA) && !txEopPend
    && txCnt != '0;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      txState <= hcs_pkg::TS_OFF;
      txSh <= `HCS_ONES;
      txBc <= '0;
      txOnes <= '0;
      txStuff <= 1'b0;
      txStuffLast <= 1'b0;
      txEopPend <= 1'b0;
      txCrc <= `HCS_CRC_INIT;
      txBit <= 1'b1;
      txEv <= '0;
    end else begin
      txEv <= '0;
      if (txState == hcs_pkg::TS_OFF) begin
        txBit <= 1'b1;
        if (bitEn && txOn) txState <= hcs_pkg::TS_IDLE;
      end else if (bitEn && txIns) begin
        txBit <= 1'b0;
        txOnes <= '0;
      end else if (bitEn) begin
        txBit <= txSh[0];
        txSh <= {1'b0, txSh[7:1]};
        txBc <= txBc + 3'd1;
        txStuffLast <= txStuff;
        txOnes <= !txSh[0] ? 3'd0 : (txOnes == 3'd7 ? 3'd7 : txOnes + 3'd1);
      end
      if (txEnd) begin
        unique case (txState)
          hcs_pkg::TS_OPEN, hcs_pkg::TS_DATA: begin
            if (txEopPend) begin
              txSh <= ~txCrc[7:0];
              txStuff <= 1'b1;
              txEopPend <= 1'b0;
              txState <= hcs_pkg::TS_FCS1;
            end else if (txCnt == '0 || txHead.abort) begin
              txSh <= `HCS_ONES;
              txStuff <= 1'b0;
              txState <= hcs_pkg::TS_ABORT;
              txEv[1] <= 1'b1;
            end else begin
              txSh <= txHead.data;
              txStuff <= 1'b1;
              txEopPend <= txHead.eop;
              txCrc <= crcByte(txState == hcs_pkg::TS_OPEN ? `HCS_CRC_INIT : txCrc, txHead.data);
              txState <= hcs_pkg::TS_DATA;
            end
          end
          hcs_pkg::TS_FCS1: begin
            txSh <= ~txCrc[15:8];
            txState <= hcs_pkg::TS_FCS2;
          end
          hcs_pkg::TS_FCS2: begin
            txSh <= `HCS_FLAG;
            txStuff <= 1'b0;
            txState <= hcs_pkg::TS_CLOSE;
            txEv[0] <= 1'b1;
          end
          default: begin
            // idle, close and abort all end at a byte boundary here
            txStuff <= 1'b0;
            if (!txOn) begin
              txSh <= `HCS_ONES;
              txState <= hcs_pkg::TS_OFF;
            end else if (txCnt != '0) begin
              txSh <= `HCS_FLAG;
              txState <= hcs_pkg::TS_OPEN;
            end else begin
              txSh <= ctrl1[`HCS_C1_FILL] ? `HCS_FLAG : `HCS_ONES;
              txState <= hcs_pkg::TS_IDLE;
            end
          end
        endcase
      end
    end
  end
  // receiver
  logic [7:0] rxSh, rxPend, rxByte;
  logic [2:0] rxBc, rxOnes;
  logic rxSync, rxFirst, rxHave, rxPendFirst, rxKeep, rxRun, rxTick;
  logic [15:0] rxCrc;
  logic [3:0] idleRun;
  logic idleChan;
  // running until the packet in progress has closed
  assign rxRun = rxOn || rxHave || !rxFirst;
  assign rxTick = bitEn && rxRun;
  assign rxByte = {rxBit, rxSh[7:1]};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxSh <= '0;
      rxPend <= '0;
      rxBc <= '0;
      rxOnes <= '0;
      rxSync <= 1'b0;
      rxFirst <= 1'b1;
      rxHave <= 1'b0;
      rxPendFirst <= 1'b0;
      rxKeep <= 1'b0;
      rxCrc <= `HCS_CRC_INIT;
      rxPushV <= 1'b0;
      rxPushEnt <= '0;
    end else begin
      rxPushV <= 1'b0;
      if (rxTick) begin
        rxOnes <= !rxBit ? 3'd0 : (rxOnes == 3'd7 ? 3'd7 : rxOnes + 3'd1);
        if ((!rxBit && rxOnes == 3'd6) || (rxBit && rxOnes >= 3'd6)) begin
          // flag closes a packet; seven ones abort it
          rxSync <= !rxBit;
          rxBc <= '0;
          rxFirst <= 1'b1;
          rxHave <= 1'b0;
          rxCrc <= `HCS_CRC_INIT;
          if (rxHave && rxKeep) begin
            rxPushV <= 1'b1;
            rxPushEnt <= '{kind: (!rxBit && rxCrc == `HCS_CRC_GOOD) ? `HCS_RQ_GOOD : `HCS_RQ_BAD, data: rxPend};
          end
        end else if (rxSync && !(!rxBit && rxOnes == 3'd5)) begin
          rxSh <= rxByte;
          rxBc <= rxBc + 3'd1;
          if (rxBc == 3'd7) begin
            rxCrc <= crcByte(rxCrc, rxByte);
            rxPend <= rxByte;
            rxHave <= 1'b1;
            rxPendFirst <= rxFirst;
            rxFirst <= 1'b0;
            if (rxFirst) begin
              rxKeep <= !ctrl1[`HCS_C1_ADREC] || rxByte[7:1] == RECOG_ADDR
                || rxByte[7:1] == `HCS_ALLCALL;
            end else if (rxHave && rxKeep) begin
              rxPushV <= 1'b1;
              rxPushEnt <= '{kind: rxPendFirst ? `HCS_RQ_FIRST : `HCS_RQ_PKT, data: rxPend};
            end
          end
        end
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      idleRun <= '0;
      idleChan <= 1'b0;
    end else if (rxTick) begin
      if (rxBit) begin
        if (idleRun != `HCS_IDLE_ONES) idleRun <= idleRun + 4'd1;
        idleChan <= idleRun >= `HCS_IDLE_ONES - 4'd1;
      end else begin
        idleRun <= '0;
        idleChan <= 1'b0;
      end
    end
  end
  // interrupts
  logic [3:0] evt, irqStat, irqMask;
  logic intgen;
  assign evt = {txEv[1], txEv[0], rxPush && rxPushEnt.kind[1], rxOvf};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irqStat <= '0;
      irqMask <= '0;
      intgen <= 1'b0;
      irq <= 1'b0;
    end else begin
      irqStat <= (irqStat & ~(wrIrq ? wb_dat_i[3:0] : 4'h0)) | evt;
      if (wrMask) irqMask <= wb_dat_i[3:0];
      if (|(evt & irqMask)) intgen <= 1'b1;
      else if (rdIrq) intgen <= 1'b0;
      irq <= |(irqStat & irqMask);
    end
  end
  // read path; the status address has no write side
  logic [7:0] next_rdData;
  always_comb begin
    case (idx)
      `HCS_IDX_FIFO: next_rdData = rxMem[rxRp].data;
      `HCS_IDX_CTRL1: next_rdData = ctrl1;
      `HCS_IDX_STAT: next_rdData = {intgen, idleChan, byteType, txLevel, rxLevel};
      `HCS_IDX_IRQST: next_rdData = {4'h0, irqStat};
      `HCS_IDX_IRQMSK: next_rdData = {4'h0, irqMask};
      default: next_rdData = 8'h00;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wbReq;
      wb_dat_o <= wbRd ? {24'h000000, next_rdData} : 32'h00000000;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ackOnce;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  busAck_a: assert property (busReq |=> ackOnce) else $error("bus ack not one cycle");
  tagClr_a: assert property (wrFifo |=> ctrl1[4:3] == 2'b00) else $error("tags kept");
  tagStore_a: assert property (txPush |=> txMem[$past(txWp)].abort == $past(ctrl1[3])) else $error("tag lost");
  statRo_a: assert property (wbWr && idx == `HCS_IDX_STAT |=> $stable(ctrl1) && $stable(irqMask))
    else $error("status write had effect");
  txStart_a: assert property (txState == hcs_pkg::TS_OFF && txOn && bitEn |=> txState == hcs_pkg::TS_IDLE)
    else $error("tx not enabled");
  txOff_a: assert property (txState == hcs_pkg::TS_OFF |=> txBit) else $error("tx line not idle");
  fillSel_a: assert property (txEnd && txState == hcs_pkg::TS_IDLE && txOn && txCnt == '0
    |=> txSh == ($past(ctrl1[2]) ? `HCS_FLAG : `HCS_ONES)) else $error("wrong fill");
  rxGate_a: assert property (bitEn && !rxRun |=> $stable(rxSh) && $stable(rxBc)) else $error("rx ran");
  txLvl_a: assert property (txCnt == '0 |-> txLevel == 2'b10) else $error("tx level");
  rxLvl_a: assert property (rxCnt >= INTL |-> rxLevel == 2'b11) else $error("rx level");
  intClr_a: assert property (rdIrq && !(|(evt & irqMask)) |=> !intgen) else $error("intgen kept");
  idleSet_a: assert property (rxTick && rxBit && idleRun == 4'd14 |=> idleChan) else $error("idle missed");
  byteType_a: assert property (rxPop |=> byteType == $past(rxMem[rxRp].kind)) else $error("byte type");
  irqOut_a: assert property (|(irqStat & irqMask) |=> irq) else $error("irq low");
endmodule : hcs_hdlc_ctl
`default_nettype wire

/* File: hcs_link_model.sv */
`default_nettype none
module hcs_link_model (
  // system
  input wire logic clk,
  input wire logic reset_n,
  // serial link
  input wire logic bitStrobe,
  input wire logic txBit,
  output logic rxBit,
  // observation
  output int zeroCount
);
  timeunit 1ns;
  timeprecision 1ns;
  // channel looped back: the far end returns each sent bit one bit time later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rxBit <= 1'b1;
      zeroCount <= 0;
    end else if (bitStrobe) begin
      rxBit <= txBit;
      zeroCount <= zeroCount + (txBit ? 0 : 1);
    end
  end
endmodule : hcs_link_model
`default_nettype wire

/* File: hdlc_control_status_bench.sv */
`include "hcs_defines.svh"
`default_nettype none
module hdlc_control_status_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BitCyc = 4;
  localparam logic [7:0] AFifo = {`HCS_IDX_FIFO, 2'b00};
  localparam logic [7:0] ACtrl = {`HCS_IDX_CTRL1, 2'b00};
  localparam logic [7:0] AStat = {`HCS_IDX_STAT, 2'b00};
  localparam logic [7:0] AIrqSt = {`HCS_IDX_IRQST, 2'b00};
  localparam logic [7:0] AMask = {`HCS_IDX_IRQMSK, 2'b00};
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h1;
  logic [31:0] datW = 32'h0;
  logic [31:0] datR;
  logic [31:0] rd;
  logic ack, irq, rxBit, txBit, bitStrobe;
  int zeroCount, zBefore;
  int num_errors = 0;
  int n_checks = 0;
  int cycles = 0;

  hcs_hdlc_ctl #(.BIT_CYC(BitCyc)) hcs_hdlc_ctl_i (.clk(clk), .reset_n(reset_n), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW), .wb_dat_o(datR),
    .wb_ack_o(ack), .rxBit(rxBit), .txBit(txBit), .bitStrobe(bitStrobe), .irq(irq));
  hcs_link_model hcs_link_model_i (.clk(clk), .reset_n(reset_n), .bitStrobe(bitStrobe), .txBit(txBit),
    .rxBit(rxBit), .zeroCount(zeroCount));

  task automatic report_and_stop();
    if (num_errors == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // one classic cycle; request held until ack is sampled high
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    datW <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    chk("bus ack", {31'h0, ack}, 32'h1);
    rd = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus

  task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp, input string what);
    bus(1'b0, a, 8'h00);
    chk(what, rd & m, exp);
  endtask : rdchk

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    chk("irq raised", {31'h0, irq}, 32'h1);
  endtask : wait_irq

  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 3);
  endfunction : pat

  initial begin
    forever #25 clk = ~clk;
  end

  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rdchk(ACtrl, 32'hff, 32'h00, "ctrl reset");
    rdchk(AStat, 32'hbf, 32'h08, "status reset");
    bus(1'b1, AStat, 8'hff);
    rdchk(AStat, 32'hbf, 32'h08, "status after write");
    rdchk(8'hfc, 32'hffffffff, 32'h0, "unmapped read");
    bus(1'b1, AMask, 8'h02);
    rdchk(AMask, 32'hff, 32'h02, "mask readback");
    // transmitter off, so the queue only fills
    for (int i = 0; i < 12; i++) begin
      if (i == 11) bus(1'b1, ACtrl, 8'h10);
      bus(1'b1, AFifo, pat(i));
      if (i == 0) rdchk(AStat, 32'h0c, 32'h0c, "tx below threshold");
      if (i == 7) rdchk(AStat, 32'h0c, 32'h04, "tx at threshold");
    end
    rdchk(ACtrl, 32'hff, 32'h00, "end tag cleared");
    rdchk(AStat, 32'h0c, 32'h00, "tx status level");
    bus(1'b1, ACtrl, 8'h40);
    repeat (20 * BitCyc) @(posedge clk);
    rdchk(AStat, 32'h40, 32'h40, "idle channel");
    bus(1'b1, ACtrl, 8'h60);
    wait_irq();
    rdchk(AStat, 32'h8f, 32'h8b, "intgen and levels");
    rdchk(AIrqSt, 32'h0f, 32'h06, "events");
    rdchk(AStat, 32'h80, 32'h00, "intgen read clear");
    chk("irq held", {31'h0, irq}, 32'h1);
    bus(1'b1, AIrqSt, 8'h0f);
    repeat (2) @(posedge clk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    // twelve data bytes and two check bytes come back
    for (int i = 0; i < 14; i++) begin
      bus(1'b0, AFifo, 8'h00);
      if (i < 12) chk("rx data", rd, {24'h0, pat(i)});
      rdchk(AStat, 32'h30, (i == 0) ? 32'h10 : (i == 13) ? 32'h20 : 32'h00, "byte type");
    end
    rdchk(AStat, 32'h03, 32'h00, "rx empty");
    zBefore = zeroCount;
    repeat (40 * BitCyc) @(posedge clk);
    chk("ones fill", 32'(zeroCount - zBefore), 32'h0);
    bus(1'b1, ACtrl, 8'h64);
    zBefore = zeroCount;
    repeat (40 * BitCyc) @(posedge clk);
    chk("flag fill", {31'h0, zeroCount > zBefore}, 32'h1);
    bus(1'b1, AMask, 8'h08);
    bus(1'b1, ACtrl, 8'h28);
    bus(1'b1, AFifo, 8'h55);
    wait_irq();
    rdchk(AIrqSt, 32'h08, 32'h08, "abort event");
    rdchk(ACtrl, 32'hff, 32'h20, "abort tag cleared");
    bus(1'b1, AIrqSt, 8'h0f);
    bus(1'b1, AMask, 8'h04);
    // a foreign address is dropped, the all-call address is kept
    for (int k = 0; k < 2; k++) begin
      bus(1'b1, ACtrl, 8'he0);
      bus(1'b1, AFifo, (k == 0) ? 8'h04 : 8'hfe);
      bus(1'b1, ACtrl, 8'hf0);
      bus(1'b1, AFifo, 8'h5a);
      wait_irq();
      bus(1'b1, AIrqSt, 8'h0f);
      repeat (30 * BitCyc) @(posedge clk);
      rdchk(AStat, 32'h03, (k == 0) ? 32'h00 : 32'h01, "address filter");
    end
    // transmitter off mid-packet: the packet completes, then the line rests at ones
    bus(1'b1, ACtrl, 8'h60);
    bus(1'b1, AFifo, 8'h11);
    bus(1'b1, ACtrl, 8'h70);
    bus(1'b1, AFifo, 8'h22);
    repeat (16 * BitCyc) @(posedge clk);
    bus(1'b1, ACtrl, 8'h44);
    wait_irq();
    repeat (30 * BitCyc) @(posedge clk);
    zBefore = zeroCount;
    repeat (40 * BitCyc) @(posedge clk);
    chk("tx stopped", 32'(zeroCount - zBefore), 32'h0);
    rdchk(AStat, 32'h0f, 32'h0b, "packet finished");
    report_and_stop();
  end
endmodule : hdlc_control_status_bench
`default_nettype wire
